// ---- hw/cus_defs.svh ----
`ifndef CUS_DEFS_SVH
`define CUS_DEFS_SVH

// Register byte addresses on the APB side
`define CUS_ADDR_CTRL     8'h00
`define CUS_ADDR_STATUS   8'h04
`define CUS_ADDR_CS_PTR   8'h08
`define CUS_ADDR_CS_PORT  8'h0c
`define CUS_ADDR_U_PTR    8'h10
`define CUS_ADDR_U_PORT   8'h14
`define CUS_ADDR_CS_BASE  8'h20
`define CUS_ADDR_U_BASE   8'h80

// Buffer geometry: 24 words of 16 bits per buffer
`define CUS_NWORDS        24
`define CUS_WIN_WORDS     6'd24
`define CUS_LAST_WORD     5'd23

// Block timing in frames
`define CUS_LAST_FRAME    8'd191
`define CUS_CRC_FIRST     8'd184

// Check byte generator
`define CUS_CRC_INIT      8'hff
`define CUS_CRC_POLY      8'h1d

// Control field positions and reset value
`define CUS_CTRL_INHIBIT  0
`define CUS_CTRL_TWO_BYTE 1
`define CUS_CTRL_SEL_B    2
`define CUS_CTRL_U_BLOCK  3
`define CUS_CTRL_IRQ_EN   4
`define CUS_CTRL_RESET    5'h00

// Status field positions
`define CUS_STAT_XFER     0

`endif

// ---- hw/cus_pkg.sv ----
package cus_pkg;

   // Control register, bit 4 down to bit 0
   typedef struct packed {
      logic irq_en;       // Interrupt on each staging-to-transmit copy
      logic user_block;   // 1: send buffered user bits, 0: send zeros
      logic sel_b;        // Single-byte reads return the channel B byte
      logic two_byte;     // Paired-byte access to the status buffer
      logic inhibit;      // Hold off staging-to-transmit copies
   } cus_ctrl_t;

   // Bits presented to the line encoder for one frame
   typedef struct packed {
      logic cs_a;
      logic cs_b;
      logic user_a;
      logic user_b;
   } cus_tx_bits_t;

endpackage

// ---- hw/cus_pin_sync.sv ----
`timescale 1ns/1ps

// Two-stage synchroniser with a rising-edge flag on the settled level
module cus_pin_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);

   logic meta_q;    // First stage, read only by the second
   logic sync_q;    // Settled level
   logic prev_q;    // Level one cycle back, for the edge

   // Only sync_q and prev_q feed logic; meta_q may be metastable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;

endmodule

// ---- hw/cus_crc8.sv ----
`timescale 1ns/1ps
`include "cus_defs.svh"

// Serial check byte generator, fed one status bit per frame
module cus_crc8 (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       step,       // Take data_bit this cycle
   input  wire logic       restart,    // First bit of a block
   input  wire logic       data_bit,
   output logic [7:0]      crc_q
);

   // One shift of the generator polynomial
   function automatic logic [7:0] crc_next(input logic [7:0] c, input logic b);
      logic [7:0] n;
      n = {c[6:0], 1'b0};
      if (c[7] ^ b) begin
         n = n ^ `CUS_CRC_POLY;
      end
      return n;
   endfunction

   // Restart folds the preset in, so the first bit is not lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_q <= `CUS_CRC_INIT;
      end else if (step) begin
         crc_q <= crc_next(restart ? `CUS_CRC_INIT : crc_q, data_bit);
      end
   end

endmodule

// ---- hw/cus_buffer_mgr.sv ----
`timescale 1ns/1ps
`include "cus_defs.svh"

module cus_buffer_mgr
   import cus_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_clk_pin,
   input  wire logic        block_start_pin,
   input  wire logic        hw_mode_pin,
   input  wire logic        cs_serial_pin,
   output cus_tx_bits_t     tx_bits,
   output logic             xfer_irq
);

   // Buffers: staging (host side) and transmit (line side)
   logic [15:0]  cs_e_q [0:`CUS_NWORDS-1];   // Status staging
   logic [15:0]  cs_f_q [0:`CUS_NWORDS-1];   // Status transmit
   logic [15:0]  u_e_q  [0:`CUS_NWORDS-1];   // User staging
   logic [15:0]  u_f_q  [0:`CUS_NWORDS-1];   // User transmit

   cus_ctrl_t    ctrl_q;                     // Control register
   logic         flag_q;                     // Sticky copy flag
   logic [4:0]   cs_ptr_q;                   // Status stream pointer
   logic [4:0]   u_ptr_q;                    // User stream pointer
   logic [31:0]  prdata_q;                   // Read data, caught at setup
   logic         pready_q;                   // High in the access phase
   logic         pslverr_q;                  // Unmapped address answer
   logic         irq_q;                      // Interrupt output

   // Address decode results
   logic         dec_cs;                     // Status buffer word
   logic         dec_u;                      // User buffer word
   logic         dec_csport;                 // Status stream port
   logic         dec_uport;                  // User stream port
   logic         dec_ok;                     // Address is mapped
   logic [4:0]   dec_idx;                    // Word index in buffer
   logic [31:0]  rd_mux;                     // Read value before capture
   logic         acc;                        // Transfer completes now
   logic         wr;                         // Completing write

   // Line side
   logic         frame_rise;                 // New frame edge seen
   logic         blk_lvl;                    // Block start level
   logic         hw_lvl;                     // Serial status source selected
   logic         ser_lvl;                    // Serial status bit
   logic [7:0]   frame_q;                    // Frame index in the block
   logic         step_q;                     // Frame index just moved
   logic         boundary;                   // Block boundary this cycle
   logic         xfer;                       // Copy staging to transmit
   logic         raw_a;                      // Status bit before check byte
   logic         raw_b;
   logic         pro_a_q;                    // Block A is professional
   logic         pro_b_q;
   logic [7:0]   crc_a;                      // Running check bytes
   logic [7:0]   crc_b;
   logic         crc_feed;                   // Bit belongs to checked span
   logic [15:0]  cs_word;                    // Transmit words in use
   logic [15:0]  u_word;
   cus_tx_bits_t tx_q;                       // Output bits

   // Window hit test for a 24-word block at base
   function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] off;
      off = a - base;
      return (a >= base) && (off[1:0] == 2'b00) && (off[7:2] < `CUS_WIN_WORDS);
   endfunction

   // Word index inside a window
   function automatic logic [4:0] win_idx(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] off;
      off = a - base;
      return off[6:2];
   endfunction

   // Status word as the host sees it in the chosen access mode
   function automatic logic [31:0] cs_read(input logic [15:0] w, input cus_ctrl_t c);
      if (c.two_byte) begin
         return {16'h0000, w};
      end else if (c.sel_b) begin
         return {24'h000000, w[7:0]};
      end else begin
         return {24'h000000, w[15:8]};
      end
   endfunction

   // Status word after a host write in the chosen access mode
   function automatic logic [15:0] cs_write(input logic [31:0] d, input cus_ctrl_t c);
      if (c.two_byte) begin
         return d[15:0];
      end else begin
         return {d[7:0], d[7:0]};
      end
   endfunction

   // Pointer step with wrap at the end of the block
   function automatic logic [4:0] ptr_inc(input logic [4:0] p);
      return (p == `CUS_LAST_WORD) ? 5'h00 : p + 5'h01;
   endfunction

   // Decode: stream ports first, then the two buffer windows
   always_comb begin
      dec_cs     = 1'b0;
      dec_u      = 1'b0;
      dec_csport = 1'b0;
      dec_uport  = 1'b0;
      dec_ok     = 1'b1;
      dec_idx    = 5'h00;
      if (paddr == `CUS_ADDR_CS_PORT) begin
         dec_cs     = 1'b1;
         dec_csport = 1'b1;
         dec_idx    = cs_ptr_q;
      end else if (paddr == `CUS_ADDR_U_PORT) begin
         dec_u     = 1'b1;
         dec_uport = 1'b1;
         dec_idx   = u_ptr_q;
      end else if (in_win(paddr, `CUS_ADDR_CS_BASE)) begin
         dec_cs  = 1'b1;
         dec_idx = win_idx(paddr, `CUS_ADDR_CS_BASE);
      end else if (in_win(paddr, `CUS_ADDR_U_BASE)) begin
         dec_u   = 1'b1;
         dec_idx = win_idx(paddr, `CUS_ADDR_U_BASE);
      end else if (paddr == `CUS_ADDR_CTRL || paddr == `CUS_ADDR_STATUS ||
                   paddr == `CUS_ADDR_CS_PTR || paddr == `CUS_ADDR_U_PTR) begin
         dec_ok = 1'b1;
      end else begin
         dec_ok = 1'b0;                                              // Unmapped
      end
   end

   // Read value; user words always come back as a pair
   always_comb begin
      if (dec_cs) begin
         rd_mux = cs_read(cs_e_q[dec_idx], ctrl_q);
      end else if (dec_u) begin
         rd_mux = {16'h0000, u_e_q[dec_idx]};
      end else if (paddr == `CUS_ADDR_CTRL) begin
         rd_mux = {27'h0000000, ctrl_q};
      end else if (paddr == `CUS_ADDR_STATUS) begin
         rd_mux = {16'h0000, frame_q, 7'h00, flag_q};
      end else if (paddr == `CUS_ADDR_CS_PTR) begin
         rd_mux = {27'h0000000, cs_ptr_q};
      end else if (paddr == `CUS_ADDR_U_PTR) begin
         rd_mux = {27'h0000000, u_ptr_q};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   assign acc = psel & penable & pready_q;
   assign wr  = acc & pwrite;

   // APB answer: ready in the first access cycle, data caught at setup
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel & ~penable;
         if (psel & ~penable) begin
            prdata_q  <= rd_mux;
            pslverr_q <= ~dec_ok;
         end
      end
   end

   // Control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= cus_ctrl_t'(`CUS_CTRL_RESET);
      end else if (wr && paddr == `CUS_ADDR_CTRL) begin
         ctrl_q <= cus_ctrl_t'(pwdata[4:0]);
      end
   end

   // Stream pointers: set directly, or stepped by each port access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_ptr_q <= 5'h00;
         u_ptr_q  <= 5'h00;
      end else if (acc) begin
         if (pwrite && paddr == `CUS_ADDR_CS_PTR) begin
            cs_ptr_q <= (pwdata[4:0] > `CUS_LAST_WORD) ? 5'h00 : pwdata[4:0];
         end else if (pwrite && paddr == `CUS_ADDR_U_PTR) begin
            u_ptr_q <= (pwdata[4:0] > `CUS_LAST_WORD) ? 5'h00 : pwdata[4:0];
         end else if (dec_csport) begin
            cs_ptr_q <= ptr_inc(cs_ptr_q);
         end else if (dec_uport) begin
            u_ptr_q <= ptr_inc(u_ptr_q);
         end
      end
   end

   // Staging buffers take host writes; a copy reads the old contents
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `CUS_NWORDS; i++) begin
            cs_e_q[i] <= 16'h0000;
            u_e_q[i]  <= 16'h0000;
         end
      end else if (wr && dec_cs) begin
         cs_e_q[dec_idx] <= cs_write(pwdata, ctrl_q);
      end else if (wr && dec_u) begin
         u_e_q[dec_idx] <= pwdata[15:0];
      end
   end

   // Link pins cross into the clock domain
   cus_pin_sync u_sync_frame (.clk(clk), .rst_n(rst_n), .pin(frame_clk_pin),   .level(),        .rise(frame_rise));
   cus_pin_sync u_sync_block (.clk(clk), .rst_n(rst_n), .pin(block_start_pin), .level(blk_lvl), .rise());
   cus_pin_sync u_sync_hw    (.clk(clk), .rst_n(rst_n), .pin(hw_mode_pin),     .level(hw_lvl),  .rise());
   cus_pin_sync u_sync_ser   (.clk(clk), .rst_n(rst_n), .pin(cs_serial_pin),   .level(ser_lvl), .rise());

   // Boundary: external block start, or the block's own wrap
   assign boundary = frame_rise & (blk_lvl | (frame_q == `CUS_LAST_FRAME));
   assign xfer     = boundary & ~ctrl_q.inhibit;

   // Frame counter follows the output timebase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q <= 8'h00;
         step_q  <= 1'b0;
      end else begin
         step_q <= frame_rise;
         if (boundary) begin
            frame_q <= 8'h00;
         end else if (frame_rise) begin
            frame_q <= frame_q + 8'h01;
         end
      end
   end

   // Whole-block copy in one cycle, so no block mixes old and new
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `CUS_NWORDS; i++) begin
            cs_f_q[i] <= 16'h0000;
            u_f_q[i]  <= 16'h0000;
         end
      end else if (xfer) begin
         for (int i = 0; i < `CUS_NWORDS; i++) begin
            cs_f_q[i] <= cs_e_q[i];
            u_f_q[i]  <= u_e_q[i];
         end
      end
   end

   // Sticky copy flag; a new copy wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         flag_q <= (flag_q & ~(wr && paddr == `CUS_ADDR_STATUS && pwdata[`CUS_STAT_XFER])) | xfer;
         irq_q  <= flag_q & ctrl_q.irq_en;
      end
   end

   // Bit selection: MSB first, user A bit before B bit
   assign cs_word = cs_f_q[frame_q[7:3]];
   assign u_word  = u_f_q[frame_q[7:3]];
   assign raw_a   = hw_lvl ? ser_lvl : cs_word[{1'b1, ~frame_q[2:0]}];
   assign raw_b   = hw_lvl ? ser_lvl : cs_word[{1'b0, ~frame_q[2:0]}];
   assign crc_feed = step_q & (frame_q < `CUS_CRC_FIRST);

   cus_crc8 u_crc_a (.clk(clk), .rst_n(rst_n), .step(crc_feed), .restart(frame_q == 8'h00),
                     .data_bit(raw_a), .crc_q(crc_a));
   cus_crc8 u_crc_b (.clk(clk), .rst_n(rst_n), .step(crc_feed), .restart(frame_q == 8'h00),
                     .data_bit(raw_b), .crc_q(crc_b));

   // Professional flag is the first bit of each channel's block
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pro_a_q <= 1'b0;
         pro_b_q <= 1'b0;
      end else if (step_q && frame_q == 8'h00) begin
         pro_a_q <= raw_a;
         pro_b_q <= raw_b;
      end
   end

   // Output bits, one update per frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_q <= '0;
      end else if (step_q) begin
         // Last byte of a professional block carries the check byte
         tx_q.cs_a <= (pro_a_q && frame_q >= `CUS_CRC_FIRST) ? crc_a[~frame_q[2:0]] : raw_a;
         tx_q.cs_b <= (pro_b_q && frame_q >= `CUS_CRC_FIRST) ? crc_b[~frame_q[2:0]] : raw_b;
         if (ctrl_q.user_block) begin
            tx_q.user_a <= u_word[{~frame_q[2:0], 1'b1}];
            tx_q.user_b <= u_word[{~frame_q[2:0], 1'b0}];
         end else begin
            tx_q.user_a <= 1'b0;
            tx_q.user_b <= 1'b0;
         end
      end
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign tx_bits  = tx_q;
   assign xfer_irq = irq_q;

endmodule

// ---- tb/cus_buffer_mgr_sva.sv ----
`timescale 1ns/1ps
`include "cus_defs.svh"

// Watches the APB side, the copy interrupt and the frame-timed outputs
module cus_buffer_mgr_chk
   import cus_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_n,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [7:0]   paddr,
   input wire logic [31:0]  pwdata,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic         frame_clk_pin,
   input wire logic         block_start_pin,
   input wire logic         hw_mode_pin,
   input wire logic         cs_serial_pin,
   input wire cus_tx_bits_t tx_bits,
   input wire logic         xfer_irq
);
   logic       irq_q, inh_q, user_q, pin_q; // Control shadow and last pin level
   logic [3:0] rise_cnt_q;                  // Cycles since a frame edge
   logic [5:0] off_cnt_q;                   // Cycles with user bits off
   logic       mapped;                      // Address hits a register

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   assign mapped = paddr[1:0] == 2'h0 &&
                   (paddr <= `CUS_ADDR_U_PORT || (paddr >= `CUS_ADDR_CS_BASE && paddr <= 8'hdc));

   // Control shadow, taken at the completing write edge as the slave does
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q  <= 1'b0;
         inh_q  <= 1'b0;
         user_q <= 1'b0;
      end else if (psel && penable && pready && pwrite && paddr == `CUS_ADDR_CTRL) begin
         irq_q  <= pwdata[`CUS_CTRL_IRQ_EN];
         inh_q  <= pwdata[`CUS_CTRL_INHIBIT];
         user_q <= pwdata[`CUS_CTRL_U_BLOCK];
      end
   end

   // Frame edge age; saturates so a stopped link never wraps it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q      <= 1'b0;
         rise_cnt_q <= 4'hf;
      end else begin
         pin_q <= frame_clk_pin;
         if (frame_clk_pin && !pin_q) begin
            rise_cnt_q <= 4'h0;
         end else if (rise_cnt_q != 4'hf) begin
            rise_cnt_q <= rise_cnt_q + 4'h1;
         end
      end
   end

   // Age of user-off; must outlast one frame plus output latency
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         off_cnt_q <= 6'h00;
      end else if (user_q) begin
         off_cnt_q <= 6'h00;                  // User bits on: restart the age
      end else if (off_cnt_q != 6'h3f) begin
         off_cnt_q <= off_cnt_q + 6'h01;
      end
   end

   setup_ready_a: assert property ((psel && !penable) |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
      else $error("ready without setup");
   unmapped_err_a: assert property (pready |-> pslverr == !mapped)
      else $error("wrong error response");
   err_data_a: assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0)
      else $error("error read returns data");
   irq_gate_a: assert property (xfer_irq |-> $past(irq_q))
      else $error("interrupt while disabled");
   inhibit_copy_a: assert property (($rose(xfer_irq) && $past(irq_q, 2)) |-> !($past(inh_q, 2) && $past(inh_q, 3)))
      else $error("copy while inhibited");
   tx_timing_a: assert property (!$stable(tx_bits) |-> rise_cnt_q inside {[4'd1:4'd12]})
      else $error("output bits change off frame");
   user_zero_a: assert property ((off_cnt_q > 6'd40) |-> (!tx_bits.user_a && !tx_bits.user_b))
      else $error("user bits sent in zero mode");
endmodule

bind cus_buffer_mgr cus_buffer_mgr_chk chk_u (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .frame_clk_pin(frame_clk_pin), .block_start_pin(block_start_pin), .hw_mode_pin(hw_mode_pin),
   .cs_serial_pin(cs_serial_pin), .tx_bits(tx_bits), .xfer_irq(xfer_irq)
);

// ---- tb/cus_frame_src.sv ----
`timescale 1ns/1ps

// Output timebase: a frame edge every 160 ns and a block marker on request
module cus_frame_src (
   input  wire logic run,             // Frames flow while high
   input  wire logic mark,            // Next frame starts a block
   output logic      frame_clk_pin,
   output logic      block_start_pin
);
   // Odd offset keeps frame edges clear of system clock edges
   initial begin
      frame_clk_pin = 1'b0;
      #3;
      forever begin
         #80;
         frame_clk_pin = run ? ~frame_clk_pin : 1'b0;
      end
   end
   // Marker is a level; it must span a frame edge to be seen
   assign block_start_pin = mark;
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "cus_defs.svh"

module testbench
   import cus_pkg::*;
;
   logic         clk, rst_n, psel, penable, pwrite;   // Clock, reset, APB controls
   logic [7:0]   paddr;                                // APB address
   logic [31:0]  pwdata, prdata, rd_d;                 // Bus data and last read
   logic         pready, pslverr, rd_e, xfer_irq;      // Answers
   logic         frame_clk_pin, block_start_pin, hw_mode_pin, cs_serial_pin, run, mark;
   cus_tx_bits_t tx_bits;                              // Line encoder bits
   logic [7:0]   sa [24], sb [24], ta [24], tb [24];   // Staging and transmit status bytes
   logic [15:0]  su [24], tu [24];                     // Staging and transmit user words
   bit           hw, ub;                               // Serial pin mode, user bits on
   int           miscompares, tests_run, cyc;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   cus_buffer_mgr dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_clk_pin(frame_clk_pin), .block_start_pin(block_start_pin), .hw_mode_pin(hw_mode_pin),
      .cs_serial_pin(cs_serial_pin), .tx_bits(tx_bits), .xfer_irq(xfer_irq));

   cus_frame_src src_u (.run(run), .mark(mark), .frame_clk_pin(frame_clk_pin),
      .block_start_pin(block_start_pin));

   // Hang guard: five blocks of 192 frames need about 20000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         report_and_stop();
      end
   end

   task report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_d = prdata;
      rd_e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk("prdata", ex, rd_d & m);
   endtask

   // Status byte as transmitted; serial pin mode sends the pin level
   function automatic logic [7:0] cbyte(input bit ch, input int w);
      return hw ? 8'hff : (ch ? tb[w] : ta[w]);
   endfunction

   // Check byte over frames 0..183, fed first bit first
   function automatic logic [7:0] crc_of(input bit ch);
      logic [7:0] c, d;
      c = 8'hff;
      for (int n = 0; n < 184; n++) begin
         d = cbyte(ch, n / 8);
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[7 - n % 8]) ? 8'h1d : 8'h00);
      end
      return c;
   endfunction

   // Force a block start, then compare every frame of that block
   task check_block(input bit cp);
      logic [7:0] ca, cb, da, db, pa, pb;
      int w, p;
      @(negedge frame_clk_pin);
      @(posedge clk) mark <= 1'b1;
      @(posedge frame_clk_pin);
      if (cp) begin
         ta = sa;
         tb = sb;
         tu = su;
      end
      ca = crc_of(1'b0);
      cb = crc_of(1'b1);
      pa = cbyte(1'b0, 0);
      pb = cbyte(1'b1, 0);
      for (int n = 0; n < 192; n++) begin
         @(negedge frame_clk_pin);
         w = n / 8;
         p = n % 8;
         da = (w == 23 && pa[7]) ? ca : cbyte(1'b0, w);
         db = (w == 23 && pb[7]) ? cb : cbyte(1'b1, w);
         chk("tx_bits", {28'h0, da[7-p], db[7-p], ub & tu[w][15-2*p], ub & tu[w][14-2*p]},
             {28'h0, tx_bits});
         if (n == 0) @(posedge clk) mark <= 1'b0;
      end
      $display("block test done");
   endtask

   initial begin
      {psel, penable, pwrite, hw_mode_pin, cs_serial_pin, mark, rst_n} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      run = 1'b1;
      for (int w = 0; w < 24; w++) begin
         sa[w] = {w[4:0], 3'b101};
         sb[w] = 8'h5a ^ 8'(w);
         su[w] = 16'ha5c3 ^ 16'(w * 16'h0111);
      end
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and an unmapped place
      rd(`CUS_ADDR_CTRL, 32'hffff_ffff, 32'h0);
      rd(`CUS_ADDR_STATUS, 32'h1, 32'h0);
      rd(`CUS_ADDR_CS_BASE, 32'hffff, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk("pslverr", 32'h1, {31'h0, rd_e});
      $display("reset test done");
      // Paired-byte fill through the stream port, read back direct and streamed
      apb(1'b1, `CUS_ADDR_CTRL, 32'h2);
      apb(1'b1, `CUS_ADDR_CS_PTR, 32'h0);
      for (int w = 0; w < 24; w++) apb(1'b1, `CUS_ADDR_CS_PORT, {16'h0, sa[w], sb[w]});
      rd(8'h78, 32'hffff, {16'h0, sa[22], sb[22]});
      apb(1'b1, `CUS_ADDR_CS_PTR, 32'd22);
      for (int k = 22; k < 25; k++) rd(`CUS_ADDR_CS_PORT, 32'hffff, {16'h0, sa[k%24], sb[k%24]});
      // Single-byte reads of each half and a write into both
      apb(1'b1, `CUS_ADDR_CTRL, 32'h0);
      rd(8'h24, 32'hff, {24'h0, sa[1]});
      apb(1'b1, `CUS_ADDR_CTRL, 32'h4);
      rd(8'h24, 32'hff, {24'h0, sb[1]});
      apb(1'b1, 8'h28, 32'h3c);
      sa[2] = 8'h3c;
      sb[2] = 8'h3c;
      apb(1'b1, `CUS_ADDR_CTRL, 32'h2);
      rd(8'h28, 32'hffff, 32'h3c3c);
      $display("access test done");
      // User words stay paired while status access is single-byte
      apb(1'b1, `CUS_ADDR_CTRL, 32'h0);
      apb(1'b1, `CUS_ADDR_U_PTR, 32'h0);
      for (int w = 0; w < 24; w++) apb(1'b1, `CUS_ADDR_U_PORT, {16'h0, su[w]});
      rd(8'h94, 32'hffff, {16'h0, su[5]});
      $display("user access test done");
      // Copy with interrupt, user bits off
      apb(1'b1, `CUS_ADDR_CTRL, 32'h10);
      apb(1'b1, `CUS_ADDR_STATUS, 32'h1);
      check_block(1'b1);
      rd(`CUS_ADDR_STATUS, 32'h1, 32'h1);
      chk("xfer_irq", 32'h1, {31'h0, xfer_irq});
      // Buffered user bits
      ub = 1'b1;
      apb(1'b1, `CUS_ADDR_CTRL, 32'h18);
      check_block(1'b1);
      // Professional block written just before a copy
      apb(1'b1, `CUS_ADDR_CTRL, 32'h1a);
      sa[0] = 8'h85;
      apb(1'b1, `CUS_ADDR_CS_BASE, {16'h0, sa[0], sb[0]});
      check_block(1'b1);
      // Inhibit holds the old block and the flag
      apb(1'b1, `CUS_ADDR_CTRL, 32'h1b);
      apb(1'b1, `CUS_ADDR_STATUS, 32'h1);
      apb(1'b1, `CUS_ADDR_CS_BASE, 32'h0);
      sa[0] = 8'h00;
      sb[0] = 8'h00;
      check_block(1'b0);
      rd(`CUS_ADDR_STATUS, 32'h1, 32'h0);
      chk("xfer_irq", 32'h0, {31'h0, xfer_irq});
      // Serial pin mode still gets check bytes
      apb(1'b1, `CUS_ADDR_CTRL, 32'h1a);
      hw = 1'b1;
      hw_mode_pin <= 1'b1;
      cs_serial_pin <= 1'b1;
      check_block(1'b1);
      report_and_stop();
   end
endmodule
